/* verilog/ckgcfg_pkg.sv */
// Purpose: Constants shared by the clock generator control-port design
// Assumes: 16-bit instruction form, 13-bit register addresses
// Notes:   Reset values of the three registers are plain defaults
`default_nettype none

package ckgcfg_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [12:0] ADDR_CFG = 13'h000;
    localparam logic [12:0] ADDR_RDBK = 13'h004;
    localparam logic [12:0] ADDR_PLL = 13'h010;
    localparam logic [12:0] ADDR_UPD = 13'h232;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CFG_SEP_OUT_BIT = 7;
    localparam int CFG_LSB_FIRST_BIT = 6;
    localparam int CFG_SOFT_RST_BIT = 5;
    localparam int RDBK_ACTIVE_BIT = 0;
    localparam int UPD_BIT = 0;
    localparam int PLL_SENSE_BIT = 7;
    localparam int PLL_CUR_HI = 6;
    localparam int PLL_CUR_LO = 4;
    localparam int PLL_MODE_HI = 3;
    localparam int PLL_MODE_LO = 2;
    localparam int PLL_PD_HI = 1;
    localparam int PLL_PD_LO = 0;

    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] CFG_RESET = 8'h18;
    localparam logic [7:0] CFG_SOFT_KEEP = 8'h24;
    localparam logic RDBK_RESET = 1'b0;
    localparam logic [7:0] PLL_RESET = 8'h7f;

    // ----------------------------------------
    // Field codes
    // ----------------------------------------
    localparam logic [1:0] PUMP_HIZ = 2'h0;
    localparam logic [1:0] PUMP_UP = 2'h1;
    localparam logic [1:0] PUMP_DOWN = 2'h2;
    localparam logic [1:0] PD_ASYNC = 2'h1;
    localparam logic [1:0] PD_SYNC = 2'h3;

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} ckgcfg_phase_t;
endpackage

`default_nettype wire

/* verilog/ckgcfg_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module ckgcfg_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // ckgcfg_sync

`default_nettype wire

/* verilog/ckgcfg_top.sv */
// Purpose: Serial control port and loop control register bank
// Assumes: Serial clock far slower than i_clock (at least 4 cycles per phase)
// Notes:   Serial pins are oversampled; loop outputs follow the active copy
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Config bit 7 low: data pin both ways, separate output pin released
// - Config bit 6: low MSB first, address down; high LSB first, address up
// - Config bit 5 high holds registers at defaults (config keeps bits 5 and 2) until written back low
// - Readback bit 0 picks buffered (0) or active (1) loop register on reads
// - Loop bit 7 sets detector sense: 0 positive, 1 negative
// - Pump current code n gives n+1 equal current steps
// - Pump mode: 00 high impedance, 01 source, 10 sink, 11 normal
// - Loop power-down: 01 asynchronous, 11 synchronous, others normal
// - Loop writes stay buffered until update bit copies them; bit self-clears
module ckgcfg_top
    import ckgcfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdio,
    output logic o_sdio_out,
    output logic o_sdio_oe,
    output logic o_sdo_out,
    output logic o_sdo_oe,
    output logic o_detector_sense_neg,
    output logic [2:0] o_pump_current_code,
    output logic [3:0] o_pump_current_steps,
    output logic o_pump_hiz,
    output logic o_pump_force_up,
    output logic o_pump_force_down,
    output logic o_loop_pd_async,
    output logic o_loop_pd_sync
);
    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [2:0] pins_s;
    logic sclk_s, cs_n_s, sdio_s, sclk_prev_q;

    ckgcfg_sync #(.WIDTH(3), .RESET_VAL(3'h2)) u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async({i_sclk, i_cs_n, i_sdio}),
        .o_sync(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign sdio_s = pins_s[0];

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    // ----------------------------------------
    // Register and serial state
    // ----------------------------------------
    logic [7:0] cfg_q, pll_buf_q, pll_act_q, tx_q, rd_data, rx_byte, loop_src;
    logic rb_q, is_read_q, stream_q;
    logic [15:0] shift_q, shift_d;
    logic [12:0] addr_q, next_addr, rd_addr;
    logic [3:0] bit_cnt_q;
    logic [1:0] bytes_left_q;
    ckgcfg_phase_t phase_q;

    wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
    wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
    wire lsb_first = cfg_q[CFG_LSB_FIRST_BIT];
    wire soft_rst = cfg_q[CFG_SOFT_RST_BIT];
    wire instr_done = sclk_rise && phase_q == ST_INSTR && bit_cnt_q == INSTR_LAST_BIT;
    wire byte_done = sclk_rise && phase_q == ST_DATA && bit_cnt_q[2:0] == BYTE_LAST_BIT;
    wire last_byte = !stream_q && bytes_left_q == 2'h0;
    wire wr_en = byte_done && !is_read_q;
    wire drive = !cs_n_s && phase_q == ST_DATA && is_read_q;
    wire tx_bit = lsb_first ? tx_q[0] : tx_q[7];

    // Both orders land R/W, count and address at the same shift positions
    assign shift_d = lsb_first ? {sdio_s, shift_q[15:1]} : {shift_q[14:0], sdio_s};
    assign rx_byte = lsb_first ? shift_d[15:8] : shift_d[7:0];
    assign next_addr = lsb_first ? addr_q + 13'h1 : addr_q - 13'h1;
    assign rd_addr = instr_done ? shift_d[12:0] : next_addr;

    wire wr_cfg = wr_en && addr_q == ADDR_CFG;
    wire wr_rdbk = wr_en && addr_q == ADDR_RDBK;
    wire wr_pll = wr_en && addr_q == ADDR_PLL;
    wire wr_upd = wr_en && addr_q == ADDR_UPD && rx_byte[UPD_BIT];

    // Update register always reads zero since its only bit self-clears
    assign rd_data = (rd_addr == ADDR_CFG) ? cfg_q :
                     (rd_addr == ADDR_RDBK) ? {7'h00, rb_q} :
                     (rd_addr != ADDR_PLL) ? 8'h00 :
                     rb_q ? pll_act_q : pll_buf_q;

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || cs_n_s) begin
            phase_q <= ST_INSTR;
            bit_cnt_q <= 4'h0;
        end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (instr_done) begin
                phase_q <= ST_DATA;
                bit_cnt_q <= 4'h0;
            end else if (byte_done && last_byte) begin
                phase_q <= ST_DONE;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            shift_q <= 16'h0000;
            is_read_q <= 1'b0;
            stream_q <= 1'b0;
            bytes_left_q <= 2'h0;
            addr_q <= 13'h0000;
            tx_q <= 8'h00;
        end else if (sclk_rise && phase_q != ST_DONE) begin
            shift_q <= shift_d;
            if (instr_done) begin
                is_read_q <= shift_d[15];
                bytes_left_q <= shift_d[14:13];
                stream_q <= &shift_d[14:13];
                addr_q <= shift_d[12:0];
                tx_q <= rd_data;
            end else if (byte_done) begin
                bytes_left_q <= bytes_left_q - 2'h1;
                addr_q <= next_addr;
                tx_q <= rd_data;
            end
        end else if (sclk_fall && drive) begin
            tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_sdio_out <= 1'b0;
            o_sdo_out <= 1'b0;
            o_sdio_oe <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            o_sdio_oe <= drive && !cfg_q[CFG_SEP_OUT_BIT];
            o_sdo_oe <= drive && cfg_q[CFG_SEP_OUT_BIT];
            if (sclk_fall && drive) begin
                o_sdio_out <= tx_bit;
                o_sdo_out <= tx_bit;
            end
        end
    end

    // ----------------------------------------
    // Register bank
    // ----------------------------------------
    // Config writes beat soft reset so the host can always clear bit 5
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cfg_q <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= rx_byte;
        end else if (soft_rst) begin
            cfg_q <= CFG_RESET | (cfg_q & CFG_SOFT_KEEP);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || soft_rst) begin
            rb_q <= RDBK_RESET;
            pll_buf_q <= PLL_RESET;
            pll_act_q <= PLL_RESET;
        end else begin
            if (wr_rdbk) begin
                rb_q <= rx_byte[RDBK_ACTIVE_BIT];
            end
            if (wr_pll) begin
                pll_buf_q <= rx_byte;
            end
            if (wr_upd) begin
                pll_act_q <= pll_buf_q;
            end
        end
    end

    // ----------------------------------------
    // Loop control outputs
    // ----------------------------------------
    assign loop_src = i_rst_n ? pll_act_q : PLL_RESET;
    wire [2:0] cur_code = loop_src[PLL_CUR_HI:PLL_CUR_LO];
    wire [1:0] pump_mode = loop_src[PLL_MODE_HI:PLL_MODE_LO];
    wire [1:0] pd_mode = loop_src[PLL_PD_HI:PLL_PD_LO];

    always_ff @(posedge i_clock) begin
        o_detector_sense_neg <= loop_src[PLL_SENSE_BIT];
        o_pump_current_code <= cur_code;
        o_pump_current_steps <= {1'b0, cur_code} + 4'h1;
        o_pump_hiz <= pump_mode == PUMP_HIZ;
        o_pump_force_up <= pump_mode == PUMP_UP;
        o_pump_force_down <= pump_mode == PUMP_DOWN;
        o_loop_pd_async <= pd_mode == PD_ASYNC;
        o_loop_pd_sync <= pd_mode == PD_SYNC;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_update_write;
        wr_upd && !soft_rst;
    endsequence

    a_sdo_released: assert property (o_sdo_oe |-> $past(cfg_q[CFG_SEP_OUT_BIT]) && !o_sdio_oe)
        else $error("separate output driven in bidirectional mode");
    a_addr_step: assert property (byte_done && !last_byte |=>
        addr_q == ($past(lsb_first) ? $past(addr_q) + 13'h1 : $past(addr_q) - 13'h1))
        else $error("address step direction wrong");
    a_soft_defaults: assert property (soft_rst && !wr_cfg |=>
        pll_buf_q == PLL_RESET && pll_act_q == PLL_RESET && !rb_q && cfg_q[CFG_SOFT_RST_BIT])
        else $error("soft reset did not restore defaults");
    a_readback_bank: assert property (instr_done && shift_d[12:0] == ADDR_PLL |=>
        tx_q == ($past(rb_q) ? $past(pll_act_q) : $past(pll_buf_q)))
        else $error("readback bank select wrong");
    a_sense_follow: assert property (##1 o_detector_sense_neg == $past(pll_act_q[PLL_SENSE_BIT]))
        else $error("detector sense not following active register");
    a_pump_steps: assert property (##1 o_pump_current_steps ==
        {1'b0, $past(pll_act_q[PLL_CUR_HI:PLL_CUR_LO])} + 4'h1)
        else $error("pump current steps wrong");
    a_pump_mode: assert property ($onehot0({o_pump_hiz, o_pump_force_up, o_pump_force_down})
        && o_pump_hiz == ($past(pll_act_q[PLL_MODE_HI:PLL_MODE_LO]) == PUMP_HIZ)
        && o_pump_force_up == ($past(pll_act_q[PLL_MODE_HI:PLL_MODE_LO]) == PUMP_UP))
        else $error("pump mode decode wrong");
    a_loop_pd: assert property (##1 o_loop_pd_sync == (&$past(pll_act_q[PLL_PD_HI:PLL_PD_LO]))
        && !(o_loop_pd_sync && o_loop_pd_async))
        else $error("loop power-down decode wrong");
    a_update_copy: assert property (s_update_write |=> pll_act_q == $past(pll_buf_q))
        else $error("update did not copy buffer");
    a_buffer_hold: assert property (!wr_upd && !soft_rst |=> pll_act_q == $past(pll_act_q))
        else $error("active register changed without update");
    a_reserved_zero: assert property (rd_addr == ADDR_RDBK |-> rd_data[7:1] == 7'h00)
        else $error("reserved readback bits not zero");
endmodule // ckgcfg_top

`default_nettype wire

/* test/ckgcfg_host.sv */
// Purpose: Host controller model driving the serial control port
// Assumes: Serial clock phases of 5 system clocks, clock idles low
// Notes:   One- or two-byte frames; reads use one byte; bit order follows the lsb flag
`timescale 1ns/10ps
`default_nettype none

module ckgcfg_host (
    input wire logic i_clock,
    input wire logic i_sdio_out,
    input wire logic i_sdio_oe,
    input wire logic i_sdo_out,
    input wire logic i_sdo_oe,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdio
);
    logic lsb = 1'b0;
    logic sep = 1'b0;
    logic drv = 1'b1;
    logic bit_q = 1'b0;
    logic [1:0] cnt = 2'b00;
    logic [7:0] wd2 = 8'h00;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
    end
    // Released line shows the inverse of the last bit, never a held value
    assign o_sdio = i_sdio_oe ? i_sdio_out : (drv ? bit_q : ~bit_q);

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdat, output logic [1:0] oes);
        logic [31:0] word;
        int k;
        int nbits;
        word = {rd, cnt, addr, wd, wd2};
        nbits = (cnt == 2'b01) ? 32 : 24;
        rdat = 8'h00;
        oes = 2'b00;
        o_cs_n = 1'b0;
        wait_n(5);
        for (int i = 0; i < nbits; i++) begin
            // Instruction, first byte, then the optional second byte
            k = lsb ? (i < 16 ? i + 16 : (i < 24 ? i - 8 : i - 24)) : 31 - i;
            o_sclk = 1'b0;
            drv = !(rd && i >= 16);
            if (drv) bit_q = word[k];
            wait_n(5);
            if (!drv && i < 24) begin
                rdat[k - 8] = sep ? i_sdo_out : o_sdio;
                oes = {i_sdio_oe, i_sdo_oe};
            end
            o_sclk = 1'b1;
            wait_n(5);
        end
        o_sclk = 1'b0;
        wait_n(5);
        o_cs_n = 1'b1;
        drv = 1'b1;
        wait_n(8);
    endtask
endmodule // ckgcfg_host

`default_nettype wire

/* test/ckgcfg_top_tb.sv */
// Purpose: Self-checking bench for the control port and loop register
// Assumes: Host model frames; expectations computed from field rules
// Notes:   Five corner loop values, then random ones from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none

module ckgcfg_top_tb;
    import ckgcfg_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    wire logic sclk, cs_n, sdio, sdio_out, sdio_oe, sdo_out, sdo_oe;
    wire logic sense, hiz, up, down, pda, pds;
    wire logic [2:0] code;
    wire logic [3:0] steps;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'hc4da94bb;
    logic [7:0] act, v, r;
    logic [1:0] oe;
    logic [7:0] corner [5] = '{8'h00, 8'h85, 8'hfa, 8'h3b, 8'h4f};

    initial begin
        forever #50 clock = ~clock;
    end

    ckgcfg_top ckgcfg_top_inst (.i_clock(clock), .i_rst_n(rst_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdio(sdio), .o_sdio_out(sdio_out), .o_sdio_oe(sdio_oe),
        .o_sdo_out(sdo_out), .o_sdo_oe(sdo_oe), .o_detector_sense_neg(sense),
        .o_pump_current_code(code), .o_pump_current_steps(steps), .o_pump_hiz(hiz),
        .o_pump_force_up(up), .o_pump_force_down(down), .o_loop_pd_async(pda),
        .o_loop_pd_sync(pds));

    ckgcfg_host host_inst (.i_clock(clock), .i_sdio_out(sdio_out), .i_sdio_oe(sdio_oe),
        .i_sdo_out(sdo_out), .i_sdo_oe(sdo_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));

    // ----------------------------------------
    // Expectations and helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    function automatic logic [15:0] expect_loop(input logic [7:0] x);
        return {3'h0, x[7], x[6:4], {1'b0, x[6:4]} + 4'h1, x[3:2] == 2'b00, x[3:2] == 2'b01,
                x[3:2] == 2'b10, x[1:0] == 2'b01, x[1:0] == 2'b11};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_loop(input logic [7:0] x);
        check("loop outputs", {3'h0, sense, code, steps, hiz, up, down, pda, pds},
              expect_loop(x));
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host_inst.xfer(1'b0, a, d, r, oe);
    endtask

    task automatic rd(input logic [12:0] a);
        host_inst.xfer(1'b1, a, 8'h00, r, oe);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clock);
        num_errors++;
        conclude();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        host_inst.wait_n(10);
        check("pin enables idle", {14'h0, sdio_oe, sdo_oe}, 16'h0);
        chk_loop(PLL_RESET);
        rd(ADDR_CFG);
        check("config default", {8'h0, r}, {8'h0, CFG_RESET});
        check("read enables bidir", {14'h0, oe}, 16'h2);
        act = PLL_RESET;
        for (int i = 0; i < 9; i++) begin
            seed = xorshift(seed);
            v = (i < 5) ? corner[i] : seed[7:0];
            wr(ADDR_PLL, v);
            chk_loop(act);
            rd(ADDR_PLL);
            check("buffered loop", {8'h0, r}, {8'h0, v});
            wr(ADDR_UPD, 8'h01);
            chk_loop(v);
            act = v;
        end
        rd(ADDR_UPD);
        check("update self clear", {8'h0, r}, 16'h0);
        wr(ADDR_PLL, 8'h5e);
        wr(ADDR_RDBK, 8'hff);
        rd(ADDR_RDBK);
        check("readback unused bits", {8'h0, r}, 16'h1);
        rd(ADDR_PLL);
        check("active loop read", {8'h0, r}, {8'h0, act});
        wr(ADDR_RDBK, 8'h00);
        rd(ADDR_PLL);
        check("buffer loop read", {8'h0, r}, 16'h5e);
        // Two-byte write from an unused address; only a decrement reaches the loop buffer
        host_inst.cnt = 2'b01;
        host_inst.wd2 = 8'hc6;
        wr(13'h011, 8'h93);
        host_inst.cnt = 2'b00;
        rd(ADDR_PLL);
        check("decrement second byte", {8'h0, r}, 16'hc6);
        wr(13'h123, 8'ha5);
        rd(13'h123);
        check("unmapped read", {8'h0, r}, 16'h0);
        // Soft reset set and cleared with a mirrored low nibble
        wr(ADDR_CFG, 8'h3c);
        wr(ADDR_CFG, 8'h18);
        chk_loop(PLL_RESET);
        rd(ADDR_PLL);
        check("buffer after soft reset", {8'h0, r}, {8'h0, PLL_RESET});
        wr(ADDR_CFG, 8'h99);
        host_inst.sep = 1'b1;
        rd(ADDR_PLL);
        check("separate pin read", {8'h0, r}, {8'h0, PLL_RESET});
        check("read enables sep", {14'h0, oe}, 16'h1);
        wr(ADDR_CFG, 8'h5a);
        host_inst.sep = 1'b0;
        host_inst.lsb = 1'b1;
        wr(ADDR_PLL, 8'h2c);
        rd(ADDR_PLL);
        check("lsb first read", {8'h0, r}, 16'h2c);
        wr(ADDR_UPD, 8'h01);
        chk_loop(8'h2c);
        // In LSB-first order the second byte must land one address higher
        host_inst.cnt = 2'b01;
        host_inst.wd2 = 8'hb1;
        wr(13'h00f, 8'h66);
        host_inst.cnt = 2'b00;
        rd(ADDR_PLL);
        check("increment second byte", {8'h0, r}, 16'hb1);
        conclude();
    end
endmodule // ckgcfg_top_tb

`default_nettype wire
